/* bench/smt_host_model.sv */
// Host model that writes translator settings over the link
`default_nettype none
module smt_host_model
  import smt_pkg::*;
(
  input wire logic link_clk_in,
  input wire logic busy_in,
  output logic wr_out,
  output smt_pkg::smt_cfg_t cfg_out,
  output logic pos_wr_out,
  output logic [5:0] pos_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_out = 1'b0;
    cfg_out = '0;
    pos_wr_out = 1'b0;
    pos_out = 6'h00;
  end
  // ==========================================================
  // One write strobe, then wait up to 64 link clocks for busy to drop before returning
  task automatic write(input smt_cfg_t c, input logic pw, input logic [5:0] p, output logic ok);
    ok = 1'b0;
    @(posedge link_clk_in);
    wr_out <= 1'b1;
    cfg_out <= c;
    pos_wr_out <= pw;
    pos_out <= p;
    @(posedge link_clk_in);
    wr_out <= 1'b0;
    cfg_out <= ~c;
    pos_wr_out <= ~pw;
    pos_out <= ~p;
    for (int n = 0; n < 64 && ok !== 1'b1; n++) begin
      @(posedge link_clk_in);
      ok = (busy_in === 1'b0);
    end
  endtask
endmodule
`default_nettype wire

/* bench/smt_translator_asserts.sv */
// Checker bound to the step translator ports
`default_nettype none
module smt_translator_asserts
  import smt_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic STEP_PULSE_PIN_IN,
  input wire logic DIR_PIN_IN,
  input wire logic THERMAL_WARN_IN,
  input wire logic SLEEP_IN,
  input wire logic [5:0] POSITION_OUT,
  input wire logic [2:0] RESOLUTION_OUT,
  input wire logic DIR_PIN_FLAG_OUT,
  input wire logic BOOST_ACTIVE_OUT,
  input wire logic BRIDGE_ENABLE_OUT,
  input wire smt_pkg::smt_coil_t COIL_PCT_OUT
);
  // ==========================================================
  // Sys domain checks
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);
  sequence s_pin_rise;
    ($rose(STEP_PULSE_PIN_IN) && !SLEEP_IN) ##1 (STEP_PULSE_PIN_IN && !SLEEP_IN) [*2];
  endsequence
  property p_reset; $fell(RESET_IN) |-> POSITION_OUT == 6'h08 && RESOLUTION_OUT == 3'h0; endproperty
  a_reset: assert property (p_reset) else $error("reset position wrong");
  property p_pct_zero; (POSITION_OUT == 6'h00) [*2] |-> COIL_PCT_OUT == 24'h3e8000; endproperty
  a_pct_zero: assert property (p_pct_zero) else $error("coil pct at 0 wrong");
  property p_pct_up; (POSITION_OUT == 6'h10) [*2] |-> COIL_PCT_OUT == 24'h0003e8; endproperty
  a_pct_up: assert property (p_pct_up) else $error("coil pct at 16 wrong");
  property p_pct_low; (POSITION_OUT == 6'h30) [*2] |-> COIL_PCT_OUT == 24'h000c18; endproperty
  a_pct_low: assert property (p_pct_low) else $error("coil pct at 48 wrong");
  property p_warn; THERMAL_WARN_IN [*8] |-> !BOOST_ACTIVE_OUT; endproperty
  a_warn: assert property (p_warn) else $error("boost kept in warning");
  property p_dir_flag; $stable(DIR_PIN_IN) [*7] |-> DIR_PIN_FLAG_OUT == DIR_PIN_IN; endproperty
  a_dir_flag: assert property (p_dir_flag) else $error("direction flag wrong");
  property p_pin_step; s_pin_rise |-> ##[0:3] POSITION_OUT != $past(POSITION_OUT); endproperty
  a_pin_step: assert property (p_pin_step) else $error("pin edge gave no step");
  property p_sleep; SLEEP_IN [*8] |-> !BRIDGE_ENABLE_OUT; endproperty
  a_sleep: assert property (p_sleep) else $error("bridge on in sleep");
endmodule
bind smt_translator smt_translator_asserts i_smt_translator_asserts (
  .CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .STEP_PULSE_PIN_IN(STEP_PULSE_PIN_IN),
  .DIR_PIN_IN(DIR_PIN_IN), .THERMAL_WARN_IN(THERMAL_WARN_IN), .SLEEP_IN(SLEEP_IN),
  .POSITION_OUT(POSITION_OUT), .RESOLUTION_OUT(RESOLUTION_OUT),
  .DIR_PIN_FLAG_OUT(DIR_PIN_FLAG_OUT), .BOOST_ACTIVE_OUT(BOOST_ACTIVE_OUT),
  .BRIDGE_ENABLE_OUT(BRIDGE_ENABLE_OUT), .COIL_PCT_OUT(COIL_PCT_OUT));
`default_nettype wire

/* bench/stepper_microstep_translator_bench.sv */
// Self-checking bench of the step translator
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module stepper_microstep_translator_bench
  import smt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, lrst = 1'b1, step = 1'b0, dir = 1'b1;
  logic cold = 1'b0, warn = 1'b0, sleep = 1'b0;
  logic busy, pushb, dflag, boost, bren, wr, pw, ok;
  logic [5:0] lpos, pos;
  logic [2:0] res;
  smt_cfg_t lcfg;
  smt_cfg_t cfg = '0;
  smt_coil_t pct, tgt;
  int fails = 0;
  int n_compared = 0;
  always #25 clk = ~clk;
  always #16 lclk = ~lclk;
  smt_translator #(.PWM_PERIOD_CYCLES(16'h0010)) i_smt_translator (
    .CLK_SYS_IN(clk), .RESET_IN(rst), .STEP_PULSE_PIN_IN(step), .DIR_PIN_IN(dir),
    .COLD_IN(cold), .THERMAL_WARN_IN(warn), .SLEEP_IN(sleep), .LINK_CLK_IN(lclk),
    .LINK_RESET_IN(lrst), .LINK_WR_IN(wr), .LINK_CFG_IN(lcfg), .LINK_POS_WR_IN(pw),
    .LINK_POS_IN(lpos), .LINK_BUSY_OUT(busy), .LINK_STEP_PUSH_OUT(pushb),
    .POSITION_OUT(pos), .RESOLUTION_OUT(res), .DIR_PIN_FLAG_OUT(dflag),
    .BOOST_ACTIVE_OUT(boost), .BRIDGE_ENABLE_OUT(bren), .COIL_PCT_OUT(pct),
    .COIL_TARGET_OUT(tgt));
  smt_host_model i_smt_host_model (.link_clk_in(lclk), .busy_in(busy), .wr_out(wr),
    .cfg_out(lcfg), .pos_wr_out(pw), .pos_out(lpos));
  // ==========================================================
  // Access tasks
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic hw(input logic wpos, input logic [5:0] p);
    i_smt_host_model.write(cfg, wpos, p, ok);
    if (ok === 1'b1) repeat (2) @(posedge clk);
    else begin
      fails++;
      conclude();
    end
  endtask
  task automatic pin_step();
    @(posedge clk);
    step <= 1'b1;
    repeat (5) @(posedge clk);
    step <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    lrst <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(pos, SMT_POS_RESET)
    `CHK(res, SMT_RES_SIXTEENTH)
    `CHK(pct, 24'h2c32c3)
    `CHK({boost, bren, dflag, pushb}, 4'h2)
    $display("test reset done");
    pin_step();
    `CHK(pos, 6'h09)
    cfg.step_resolution = SMT_RES_FULL;
    hw(1'b1, 6'h00);
    `CHK(pos, 6'h00)
    `CHK(pct, 24'h3e8000)
    pin_step();
    `CHK(pos, SMT_HALF_TURN)
    `CHK(pct, 24'h0003e8)
    $display("test pin stepping done");
    cfg.direction_polarity = 1'b1;
    cfg.step_resolution = SMT_RES_HALF;
    cfg.step_push = 1'b1;
    hw(1'b0, 6'h00);
    `CHK(pos, 6'h08)
    `CHK(pushb, 1'b0)
    for (int r = 0; r < 5; r++) begin
      cfg.step_resolution = 3'(r);
      hw(1'b1, 6'h00);
      `CHK(pos, 6'h00 - (6'h01 << r))
    end
    cfg.step_resolution = SMT_RES_QUARTER;
    hw(1'b1, 6'h11);
    `CHK(pos, 6'h10)
    `CHK(res, SMT_RES_QUARTER)
    dir <= 1'b0;
    repeat (4) @(posedge clk);
    hw(1'b1, 6'h11);
    `CHK(pos, 6'h14)
    $display("test link stepping done");
    cfg.step_resolution = SMT_RES_SIXTEENTH;
    cfg.step_push = 1'b0;
    hw(1'b1, 6'h00);
    pin_step();
    cfg.step_push = 1'b1;
    hw(1'b0, 6'h00);
    `CHK(pos, 6'h02)
    `CHK(dflag, 1'b0)
    sleep <= 1'b1;
    repeat (8) @(posedge clk);
    pin_step();
    `CHK(pos, 6'h02)
    sleep <= 1'b0;
    repeat (8) @(posedge clk);
    $display("test sleep done");
    cfg = '0;
    cfg.peak_current_code = 4'hf;
    cfg.cold_boost = 1'b1;
    cfg.driver_enable = 1'b1;
    hw(1'b1, SMT_HALF_TURN);
    cold <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK({boost, bren}, 2'h3)
    `CHK(tgt, 24'h00044c)
    warn <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK(boost, 1'b0)
    `CHK(tgt, 24'h000320)
    cfg.peak_current_code = 4'h0;
    hw(1'b0, 6'h00);
    repeat (40) @(posedge clk);
    `CHK(tgt, 24'h00003b)
    $display("test current done");
    conclude();
  end
endmodule
`default_nettype wire

/* core/smt_translator.sv */
// Step translator: position, stepping, coil current tables and link crossing
`default_nettype none

// Function
// - Position is a 6-bit value in sixteenth units, written and read by host.
// - Reset sets position to 8 with sixteenth resolution.
// - Resolution code 0 to 4 selects sixteenth, eighth, quarter, half, full.
// - Each position gives signed sine Y and cosine X coil percentages.
// - A trigger moves 1, 2, 4, 8 or 16 units up or down.
// - Position updates right after each trigger.
// - Direction is direction pin XOR polarity bit.
// - Positive direction counts upward, counter-clockwise current vector.
// - Direction pin level is reported as a status flag.
// - Trigger on step pin rising edge and on step push write.
// - Step push bit clears itself after its step is taken.
// - Separated pin edge and push both count, giving two steps.
// - Stepping keeps working while driver_enable disables the bridge drivers.
// - Resolution change takes effect only at the next trigger.
// - Push written with new polarity and resolution steps with new values.
// - Position write applies at once regardless of resolution.
// - Boost sets while below the cold threshold and holds until thermal warning or cold_boost clears it.
// - Thermal warning drops boost; boost state is readable.
// - Peak code 0 to F maps to 59..800 mA or 81..1100 mA boosted.
// - Lower resolution aligns to nearest valid position in direction; raise adds zeros.
// - Peak code change updates targets at next PWM period start.
// - In sleep, step pin, step push and position write leave position unchanged.
// - Driver enable gates only the bridges.
module smt_translator
  import smt_pkg::*;
#(
  parameter logic [15:0] PWM_PERIOD_CYCLES = smt_pkg::SMT_PWM_PERIOD_CYCLES
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_IN,
  input wire logic STEP_PULSE_PIN_IN,
  input wire logic DIR_PIN_IN,
  input wire logic COLD_IN,
  input wire logic THERMAL_WARN_IN,
  input wire logic SLEEP_IN,
  input wire logic LINK_CLK_IN,
  input wire logic LINK_RESET_IN,
  input wire logic LINK_WR_IN,
  input wire smt_pkg::smt_cfg_t LINK_CFG_IN,
  input wire logic LINK_POS_WR_IN,
  input wire logic [5:0] LINK_POS_IN,
  output logic LINK_BUSY_OUT,
  output logic LINK_STEP_PUSH_OUT,
  output logic [5:0] POSITION_OUT,
  output logic [2:0] RESOLUTION_OUT,
  output logic DIR_PIN_FLAG_OUT,
  output logic BOOST_ACTIVE_OUT,
  output logic BRIDGE_ENABLE_OUT,
  output smt_pkg::smt_coil_t COIL_PCT_OUT,
  output smt_pkg::smt_coil_t COIL_TARGET_OUT
);
  import smt_pkg::*;

  // ==========================================================
  // State types
  typedef struct packed {
    logic req_tgl;
    smt_req_t req;
    logic [2:0] ack_sync;
    logic ack_lvl;
    logic busy;
    logic push_bit;
  } smt_lnk_state_t;

  typedef struct packed {
    logic [SMT_PIN_W-1:0] s1;
    logic [SMT_PIN_W-1:0] s2;
    logic [SMT_PIN_W-1:0] s3;
    logic [SMT_PIN_W-1:0] lvl;
    logic req_seen;
    logic ack_tgl;
    smt_cfg_t cfg;
    logic push_pend;
    logic [5:0] pos;
    logic boost;
    logic bridge_en;
    logic [SMT_PWM_CNT_W-1:0] pwm_cnt;
    smt_coil_t pct;
    smt_coil_t target;
  } smt_sys_state_t;

  smt_lnk_state_t lnk_ff;
  smt_lnk_state_t nxt_lnk;
  smt_sys_state_t sys_ff;
  smt_sys_state_t nxt_sys;

  // ==========================================================
  // Functions
  function automatic logic [5:0] smt_step(input logic [5:0] pos, input logic [2:0] res,
                                          input logic up);
    logic [5:0] size;
    logic [5:0] base;
    begin
      case (res)
        SMT_RES_SIXTEENTH: size = SMT_SIZE_SIXTEENTH;
        SMT_RES_EIGHTH: size = SMT_SIZE_EIGHTH;
        SMT_RES_QUARTER: size = SMT_SIZE_QUARTER;
        SMT_RES_HALF: size = SMT_SIZE_HALF;
        default: size = SMT_SIZE_FULL;
      endcase
      base = pos & ~(size - SMT_SIZE_SIXTEENTH);
      if (up) begin
        smt_step = base + size;
      end else if (pos != base) begin
        smt_step = base;
      end else begin
        smt_step = base - size;
      end
    end
  endfunction

  function automatic logic signed [11:0] smt_sin(input logic [5:0] pos);
    logic [4:0] idx;
    logic [9:0] mag;
    begin
      idx = pos[4] ? (5'h10 - {1'b0, pos[3:0]}) : {1'b0, pos[3:0]};
      mag = SMT_SINE_TAB[idx];
      smt_sin = pos[5] ? -$signed({2'b00, mag}) : $signed({2'b00, mag});
    end
  endfunction

  function automatic logic signed [11:0] smt_scale(input logic signed [11:0] pct,
                                                   input logic [10:0] peak);
    logic signed [23:0] prod;
    begin
      prod = 24'(pct * $signed({1'b0, peak}));
      smt_scale = 12'(prod / SMT_PCT_FULL);
    end
  endfunction

  // ==========================================================
  // Link domain: capture host writes, hold them until acknowledged
  always_comb begin
    nxt_lnk = lnk_ff;
    nxt_lnk.ack_sync = {lnk_ff.ack_sync[1:0], sys_ff.ack_tgl};
    if (lnk_ff.ack_sync[1] == lnk_ff.ack_sync[2]) begin
      nxt_lnk.ack_lvl = lnk_ff.ack_sync[2];
    end
    if (lnk_ff.busy && (nxt_lnk.ack_lvl == lnk_ff.req_tgl)) begin
      nxt_lnk.busy = 1'b0;
      nxt_lnk.push_bit = 1'b0;
    end
    if (LINK_WR_IN && !lnk_ff.busy) begin
      nxt_lnk.req.cfg = LINK_CFG_IN;
      nxt_lnk.req.pos_wr = LINK_POS_WR_IN;
      nxt_lnk.req.translator_position = LINK_POS_IN;
      nxt_lnk.req_tgl = ~lnk_ff.req_tgl;
      nxt_lnk.busy = 1'b1;
      nxt_lnk.push_bit = LINK_CFG_IN.step_push;
    end
  end

  always_ff @(posedge LINK_CLK_IN) begin
    if (LINK_RESET_IN) begin
      lnk_ff <= '0;
    end else begin
      lnk_ff <= nxt_lnk;
    end
  end

  // ==========================================================
  // System domain: pins, stepping and current targets
  logic [SMT_PIN_W-1:0] pins;
  logic [SMT_PIN_W-1:0] agree;
  logic step_rise;
  logic req_new;
  logic dir_up;
  logic sleeping;
  logic [10:0] peak;

  assign pins = {lnk_ff.req_tgl, SLEEP_IN, THERMAL_WARN_IN, COLD_IN, DIR_PIN_IN,
                 STEP_PULSE_PIN_IN};

  always_comb begin
    nxt_sys = sys_ff;
    nxt_sys.s1 = pins;
    nxt_sys.s2 = sys_ff.s1;
    nxt_sys.s3 = sys_ff.s2;
    agree = ~(sys_ff.s2 ^ sys_ff.s3);
    nxt_sys.lvl = (agree & sys_ff.s3) | (~agree & sys_ff.lvl);
    step_rise = nxt_sys.lvl[SMT_PIN_STEP] & ~sys_ff.lvl[SMT_PIN_STEP];
    req_new = nxt_sys.lvl[SMT_PIN_REQ] != sys_ff.req_seen;
    sleeping = sys_ff.lvl[SMT_PIN_SLEEP];
    dir_up = sys_ff.lvl[SMT_PIN_DIR] ^ sys_ff.cfg.direction_polarity;

    if (step_rise && !sleeping) begin
      nxt_sys.pos = smt_step(sys_ff.pos, sys_ff.cfg.step_resolution, dir_up);
    end else if (sys_ff.push_pend) begin
      nxt_sys.push_pend = 1'b0;
      nxt_sys.ack_tgl = ~sys_ff.ack_tgl;
      if (!sleeping) begin
        nxt_sys.pos = smt_step(sys_ff.pos, sys_ff.cfg.step_resolution, dir_up);
      end
    end else if (req_new) begin
      nxt_sys.req_seen = nxt_sys.lvl[SMT_PIN_REQ];
      nxt_sys.cfg = lnk_ff.req.cfg;
      if (lnk_ff.req.pos_wr && !sleeping) begin
        nxt_sys.pos = lnk_ff.req.translator_position;
      end
      if (lnk_ff.req.cfg.step_push) begin
        nxt_sys.push_pend = 1'b1;
      end else begin
        nxt_sys.ack_tgl = ~sys_ff.ack_tgl;
      end
    end

    nxt_sys.pct.coil_y = smt_sin(nxt_sys.pos);
    nxt_sys.pct.coil_x = smt_sin(nxt_sys.pos + SMT_HALF_TURN);

    if (sys_ff.lvl[SMT_PIN_WARN]) begin
      nxt_sys.boost = 1'b0;
    end else if (!sys_ff.cfg.cold_boost) begin
      nxt_sys.boost = 1'b0;
    end else if (sys_ff.lvl[SMT_PIN_COLD]) begin
      nxt_sys.boost = 1'b1;
    end

    nxt_sys.bridge_en = sys_ff.cfg.driver_enable && !sleeping;

    peak = sys_ff.boost ? SMT_PEAK_BOOST_MA[sys_ff.cfg.peak_current_code]
                        : SMT_PEAK_MA[sys_ff.cfg.peak_current_code];
    if (sys_ff.pwm_cnt == (PWM_PERIOD_CYCLES - 16'h0001)) begin
      nxt_sys.pwm_cnt = '0;
    end else begin
      nxt_sys.pwm_cnt = sys_ff.pwm_cnt + 16'h0001;
    end
    if (sys_ff.pwm_cnt == '0) begin
      nxt_sys.target.coil_x = smt_scale(sys_ff.pct.coil_x, peak);
      nxt_sys.target.coil_y = smt_scale(sys_ff.pct.coil_y, peak);
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      sys_ff <= '0;
      sys_ff.pos <= SMT_POS_RESET;
      sys_ff.cfg.step_resolution <= SMT_RES_SIXTEENTH;
      sys_ff.cfg.direction_polarity <= SMT_POLARITY_RESET;
      sys_ff.cfg.peak_current_code <= SMT_PEAK_CODE_RESET;
      sys_ff.cfg.cold_boost <= SMT_BOOST_RESET;
      sys_ff.cfg.driver_enable <= SMT_DRIVER_ENABLE_RESET;
      sys_ff.pct.coil_x <= 12'sh2c3;
      sys_ff.pct.coil_y <= 12'sh2c3;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  // ==========================================================
  // Outputs
  assign LINK_BUSY_OUT = lnk_ff.busy;
  assign LINK_STEP_PUSH_OUT = lnk_ff.push_bit;
  assign POSITION_OUT = sys_ff.pos;
  assign RESOLUTION_OUT = sys_ff.cfg.step_resolution;
  assign DIR_PIN_FLAG_OUT = sys_ff.lvl[SMT_PIN_DIR];
  assign BOOST_ACTIVE_OUT = sys_ff.boost;
  assign BRIDGE_ENABLE_OUT = sys_ff.bridge_en;
  assign COIL_PCT_OUT = sys_ff.pct;
  assign COIL_TARGET_OUT = sys_ff.target;

endmodule
`default_nettype wire

/* shared/smt_pkg.sv */
// Constants and carrier types of the step translator
`default_nettype none
package smt_pkg;

  // ==========================================================
  // Position and step resolution
  localparam int SMT_POS_W = 6;
  localparam logic [5:0] SMT_POS_RESET = 6'h08;
  localparam logic [5:0] SMT_HALF_TURN = 6'h10;
  localparam logic [2:0] SMT_RES_SIXTEENTH = 3'h0;
  localparam logic [2:0] SMT_RES_EIGHTH = 3'h1;
  localparam logic [2:0] SMT_RES_QUARTER = 3'h2;
  localparam logic [2:0] SMT_RES_HALF = 3'h3;
  localparam logic [2:0] SMT_RES_FULL = 3'h4;
  localparam logic [5:0] SMT_SIZE_SIXTEENTH = 6'h01;
  localparam logic [5:0] SMT_SIZE_EIGHTH = 6'h02;
  localparam logic [5:0] SMT_SIZE_QUARTER = 6'h04;
  localparam logic [5:0] SMT_SIZE_HALF = 6'h08;
  localparam logic [5:0] SMT_SIZE_FULL = 6'h10;

  // ==========================================================
  // Configuration reset values
  localparam logic [3:0] SMT_PEAK_CODE_RESET = 4'h0;
  localparam logic SMT_POLARITY_RESET = 1'b0;
  localparam logic SMT_BOOST_RESET = 1'b0;
  localparam logic SMT_DRIVER_ENABLE_RESET = 1'b0;

  // ==========================================================
  // Synchronised pin vector bit positions
  localparam int SMT_PIN_W = 6;
  localparam int SMT_PIN_STEP = 0;
  localparam int SMT_PIN_DIR = 1;
  localparam int SMT_PIN_COLD = 2;
  localparam int SMT_PIN_WARN = 3;
  localparam int SMT_PIN_SLEEP = 4;
  localparam int SMT_PIN_REQ = 5;

  // ==========================================================
  // Timing
  localparam int SMT_CLK_PERIOD_NS = 32'h0000_0032;
  localparam int SMT_PWM_PERIOD_NS = 32'h0000_c350;
  localparam int SMT_PWM_CNT_W = 16;
  localparam logic [15:0] SMT_PWM_PERIOD_CYCLES =
    16'(SMT_PWM_PERIOD_NS / SMT_CLK_PERIOD_NS);

  // ==========================================================
  // Current tables: quarter sine in tenths of a percent, peaks in mA
  localparam logic signed [23:0] SMT_PCT_FULL = 24'sh0003e8;
  localparam logic [0:16][9:0] SMT_SINE_TAB = '{
    10'h000, 10'h062, 10'h0c3, 10'h122, 10'h17f, 10'h1d7, 10'h22c, 10'h27a, 10'h2c3,
    10'h305, 10'h33f, 10'h372, 10'h39c, 10'h3bd, 10'h3d5, 10'h3e3, 10'h3e8};
  localparam logic [0:15][10:0] SMT_PEAK_MA = '{
    11'h03b, 11'h047, 11'h054, 11'h064, 11'h077, 11'h08d, 11'h0a8, 11'h0c8,
    11'h0ee, 11'h11b, 11'h150, 11'h190, 11'h1dc, 11'h236, 11'h2a1, 11'h320};
  localparam logic [0:15][10:0] SMT_PEAK_BOOST_MA = '{
    11'h051, 11'h062, 11'h074, 11'h08a, 11'h0a4, 11'h0c2, 11'h0e7, 11'h113,
    11'h147, 11'h185, 11'h1ce, 11'h226, 11'h28f, 11'h30a, 11'h39d, 11'h44c};

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic [2:0] step_resolution;
    logic direction_polarity;
    logic step_push;
    logic [3:0] peak_current_code;
    logic cold_boost;
    logic driver_enable;
  } smt_cfg_t;

  typedef struct packed {
    smt_cfg_t cfg;
    logic pos_wr;
    logic [5:0] translator_position;
  } smt_req_t;

  typedef struct packed {
    logic signed [11:0] coil_x;
    logic signed [11:0] coil_y;
  } smt_coil_t;

endpackage
`default_nettype wire
